// File: hdl/branch_jump_execution.sv
/*
 * executes the conditional relative jumps, the register-indirect jumps and
 * the decrement-loop branch. one CLK edge is one t-state.
 * assumes program memory answers combinationally on MEM_DATA for the
 * address on MEM_ADDR during read cycles, and that register values and
 * flags are supplied by the surrounding core and held steady while BUSY.
 */
// Functional notes
// - 38h: relative jump when carry set
// - 30h: relative jump when carry clear
// - 28h: relative jump when zero set
// - 20h: relative jump when zero clear
// - signed displacement added after pc passes both bytes
// - taken relative jump: 4,3,5 t-states
// - untaken relative jump: 4,3 t-states
// - E9h loads pc from pointer pair, 4 t-states
// - DDh E9h loads pc from first index, 4,4
// - FDh E9h loads pc from second index, 4,4
// - 10h decrements counter, branches if nonzero: 5,3,5
// - counter zero: fall through after 5,3
`timescale 1ns/1ns
module branch_jump_execution (
    input wire logic CLK, // 10 MHz core clock
    input wire logic RST_N, // async reset, active low
    input wire logic START, // pulse: begin an instruction fetch at PC
    input wire logic [7:0] MEM_DATA, // byte read from program memory
    input wire logic [7:0] FLAGS_IN, // flag register from the core
    input wire logic [15:0] POINTER_PAIR, // pointer pair value
    input wire logic [15:0] INDEX_REG_FIRST, // first index register
    input wire logic [15:0] INDEX_REG_SECOND, // second index register
    input wire logic [7:0] LOOP_COUNT_IN, // loop counter value
    output logic [15:0] MEM_ADDR, // program memory address
    output logic MEM_RD, // memory read strobe, high during fetch cycles
    output logic [15:0] PC_OUT, // program counter
    output logic [7:0] LOOP_COUNT_OUT, // loop counter after decrement
    output logic LOOP_COUNT_WE, // pulse: write LOOP_COUNT_OUT back
    output logic [7:0] FLAGS_OUT, // flag register, passed through unchanged
    output logic BRANCH_TAKEN, // pulse: instruction ended with a branch
    output logic UNKNOWN_OP, // pulse: opcode not handled here
    output logic BUSY, // instruction in progress
    output logic DONE // pulse: instruction finished
);
    // one state per machine cycle; the index form reuses fetch timing for its second byte
    typedef enum {
        S_IDLE,
        S_FETCH,
        S_PREFIX,
        S_DISP,
        S_ADD
    } state_type;

    // registered state and the next values the sequencer computes for it
    state_type state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0] opcode_q, opcode_d;
    logic [7:0] disp_q, disp_d;
    logic [7:0] prefix_q, prefix_d;
    logic [7:0] count_q, count_d;
    logic count_we_q, count_we_d;
    logic [7:0] flags_q;
    logic taken_q, taken_d;
    logic unknown_q, unknown_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic rd_q, rd_d;
    logic [2:0] len_q, len_d;
    logic mc_start;
    logic mc_last;

    // decode of the fetched opcode
    wire is_relative = (MEM_DATA == branch_pkg::OP_JR_CARRY) || (MEM_DATA == branch_pkg::OP_JR_NO_CARRY) ||
                       (MEM_DATA == branch_pkg::OP_JR_ZERO) || (MEM_DATA == branch_pkg::OP_JR_NOT_ZERO);
    wire is_loop = (MEM_DATA == branch_pkg::OP_LOOP_BRANCH);
    wire is_pointer_jump = (MEM_DATA == branch_pkg::OP_JUMP_POINTER);
    wire is_prefix = (MEM_DATA == branch_pkg::OP_PREFIX_FIRST) || (MEM_DATA == branch_pkg::OP_PREFIX_SECOND);
    // flags come straight from the core, which holds them while busy
    wire carry = FLAGS_IN[branch_pkg::CARRY_BIT];
    wire zero = FLAGS_IN[branch_pkg::ZERO_BIT];

    // condition test per opcode
    wire cond_carry = (opcode_q == branch_pkg::OP_JR_CARRY) && carry;
    wire cond_no_carry = (opcode_q == branch_pkg::OP_JR_NO_CARRY) && !carry;
    wire cond_zero = (opcode_q == branch_pkg::OP_JR_ZERO) && zero;
    wire cond_not_zero = (opcode_q == branch_pkg::OP_JR_NOT_ZERO) && !zero;
    // loop test looks at the value after decrement, as the counter will hold it
    wire [7:0] count_dec = count_q - branch_pkg::COUNT_STEP;
    wire cond_loop = (opcode_q == branch_pkg::OP_LOOP_BRANCH) && (count_dec != branch_pkg::BYTE_ZERO);
    wire cond_met = cond_carry || cond_no_carry || cond_zero || cond_not_zero || cond_loop;

    // pc already past both bytes; sign-extend and add
    wire [15:0] disp_ext = {(disp_q[7] ? branch_pkg::SIGN_FILL : branch_pkg::BYTE_ZERO), disp_q};
    wire [15:0] pc_target = pc_q + disp_ext;
    wire [15:0] index_target = (prefix_q == branch_pkg::OP_PREFIX_FIRST) ? INDEX_REG_FIRST : INDEX_REG_SECOND;

    // counter is parked at zero while idle, so every instruction starts on t-state 0
    assign mc_start = (state_q == S_IDLE);

    // one shared counter times every machine cycle; only its last flag is used
    tstate_counter u_tstate (
        .clk(CLK),
        .rst_n(RST_N),
        .start(mc_start),
        .len(len_q),
        .last(mc_last)
    );

    // sequencer: one machine cycle per state, advanced on its last t-state
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        addr_d = addr_q;
        opcode_d = opcode_q;
        disp_d = disp_q;
        prefix_d = prefix_q;
        count_d = count_q;
        count_we_d = 1'b0;
        taken_d = 1'b0;
        unknown_d = 1'b0;
        done_d = 1'b0;
        busy_d = busy_q;
        rd_d = rd_q;
        len_d = len_q;
        case (state_q)
            S_IDLE: begin
                if (START) begin
                    state_d = S_FETCH;
                    addr_d = pc_q;
                    rd_d = 1'b1;
                    busy_d = 1'b1;
                    // a prefix left from the previous instruction must not steer this one
                    prefix_d = branch_pkg::BYTE_ZERO;
                    len_d = branch_pkg::T_LEN_FETCH;
                end
            end
            S_FETCH, S_PREFIX: begin
                // loop opcode stretches its fetch to five t-states
                if (state_q == S_FETCH && is_loop && len_q == branch_pkg::T_LEN_FETCH) begin
                    len_d = branch_pkg::T_LEN_LOOP_FETCH;
                end
                if (mc_last) begin
                    opcode_d = MEM_DATA;
                    pc_d = pc_q + branch_pkg::PC_STEP;
                    addr_d = pc_q + branch_pkg::PC_STEP;
                    len_d = branch_pkg::T_LEN_FETCH;
                    if (state_q == S_FETCH && is_prefix) begin
                        prefix_d = MEM_DATA;
                        state_d = S_PREFIX;
                    end else if (state_q == S_FETCH && is_pointer_jump) begin
                        pc_d = POINTER_PAIR;
                        state_d = S_IDLE;
                    end else if (state_q == S_PREFIX && is_pointer_jump) begin
                        pc_d = index_target;
                        state_d = S_IDLE;
                    end else if (state_q == S_FETCH && (is_relative || is_loop)) begin
                        count_d = LOOP_COUNT_IN;
                        len_d = branch_pkg::T_LEN_READ;
                        state_d = S_DISP;
                    end else begin
                        unknown_d = 1'b1;
                        state_d = S_IDLE;
                    end
                    // register-indirect jumps and foreign opcodes finish with this fetch
                    if (state_d == S_IDLE) begin
                        taken_d = !unknown_d;
                        busy_d = 1'b0;
                        done_d = 1'b1;
                        rd_d = 1'b0;
                    end
                end
            end
            S_DISP: begin
                // displacement is read whatever the condition
                if (mc_last) begin
                    disp_d = MEM_DATA;
                    pc_d = pc_q + branch_pkg::PC_STEP;
                    rd_d = 1'b0;
                    if (opcode_q == branch_pkg::OP_LOOP_BRANCH) begin
                        count_d = count_dec;
                        count_we_d = 1'b1;
                    end
                    if (cond_met) begin
                        len_d = branch_pkg::T_LEN_ADD;
                        state_d = S_ADD;
                    end else begin
                        // untaken: pc already points past both bytes
                        state_d = S_IDLE;
                        busy_d = 1'b0;
                        done_d = 1'b1;
                    end
                end
            end
            S_ADD: begin
                // pc already points past the displacement byte
                if (mc_last) begin
                    pc_d = pc_target;
                    taken_d = 1'b1;
                    state_d = S_IDLE;
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            default: begin
                // unreachable; return to idle rather than hang the core
                state_d = S_IDLE;
                busy_d = 1'b0;
                rd_d = 1'b0;
            end
        endcase
    end

    // sequencer state and the length of the running machine cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            len_q <= branch_pkg::T_LEN_FETCH;
        end else begin
            state_q <= state_d;
            len_q <= len_d;
        end
    end

    // program counter and fetch address
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pc_q <= branch_pkg::PC_RESET;
            addr_q <= branch_pkg::PC_RESET;
        end else begin
            pc_q <= pc_d;
            addr_q <= addr_d;
        end
    end

    // bytes held from the instruction stream; the prefix picks the index register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            opcode_q <= branch_pkg::BYTE_ZERO;
            disp_q <= branch_pkg::BYTE_ZERO;
            prefix_q <= branch_pkg::BYTE_ZERO;
        end else begin
            opcode_q <= opcode_d;
            disp_q <= disp_d;
            prefix_q <= prefix_d;
        end
    end

    // loop counter copy and its one-cycle write-back strobe
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            count_q <= branch_pkg::BYTE_ZERO;
            count_we_q <= 1'b0;
        end else begin
            count_q <= count_d;
            count_we_q <= count_we_d;
        end
    end

    // end-of-instruction pulses, each high for one cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            taken_q <= 1'b0;
            unknown_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            taken_q <= taken_d;
            unknown_q <= unknown_d;
            done_q <= done_d;
        end
    end

    // busy level and read strobe; plain levels so the core can watch them
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            rd_q <= rd_d;
        end
    end

    // flags are only sampled, never rewritten; the decrement leaves them alone
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_q <= branch_pkg::BYTE_ZERO;
        end else begin
            flags_q <= FLAGS_IN;
        end
    end

    // outputs come straight from registers, so the core never sees decode glitches
    assign MEM_ADDR = addr_q;
    assign MEM_RD = rd_q;
    assign PC_OUT = pc_q;
    assign LOOP_COUNT_OUT = count_q;
    assign LOOP_COUNT_WE = count_we_q;
    assign FLAGS_OUT = flags_q;
    assign BRANCH_TAKEN = taken_q;
    assign UNKNOWN_OP = unknown_q;
    assign BUSY = busy_q;
    assign DONE = done_q;
endmodule

// File: hdl/branch_pkg.sv
/*
 * constants for the branch execution block: opcodes, t-state counts per
 * machine cycle, field widths and reset values.
 * assumes a single-clock core where one CLK edge is one t-state.
 */
package branch_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // flag register bit positions tested by the conditional jumps
    localparam int CARRY_BIT = 0;
    localparam int ZERO_BIT = 6;
    // opcodes
    localparam logic [7:0] OP_JR_CARRY = 8'h38;
    localparam logic [7:0] OP_JR_NO_CARRY = 8'h30;
    localparam logic [7:0] OP_JR_ZERO = 8'h28;
    localparam logic [7:0] OP_JR_NOT_ZERO = 8'h20;
    localparam logic [7:0] OP_JUMP_POINTER = 8'hE9;
    localparam logic [7:0] OP_PREFIX_FIRST = 8'hDD;
    localparam logic [7:0] OP_PREFIX_SECOND = 8'hFD;
    localparam logic [7:0] OP_LOOP_BRANCH = 8'h10;
    // t-state lengths of machine cycles (cycle counter runs 0..len-1)
    localparam logic [2:0] T_LEN_FETCH = 3'h4;
    localparam logic [2:0] T_LEN_LOOP_FETCH = 3'h5;
    localparam logic [2:0] T_LEN_READ = 3'h3;
    localparam logic [2:0] T_LEN_ADD = 3'h5;
    localparam logic [2:0] T_ONE = 3'h1;
    localparam logic [2:0] T_ZERO = 3'h0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [7:0] COUNT_STEP = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] SIGN_FILL = 8'hFF;
    typedef enum logic [1:0] {
        COND_CARRY,
        COND_NO_CARRY,
        COND_ZERO,
        COND_NOT_ZERO
    } cond_type;
endpackage

// File: hdl/tstate_counter.sv
/*
 * counts t-states inside one machine cycle and flags the last one.
 * assumes len is held steady for the whole machine cycle and is at least 1.
 */
`timescale 1ns/1ns
module tstate_counter (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic start, // restart counting at t-state 0
    input wire logic [2:0] len, // length of the current machine cycle
    output logic last // high on the final t-state
);
    logic [2:0] count_q;
    logic [2:0] count_d;

    // last t-state once count reaches len-1
    assign last = (count_q == (len - branch_pkg::T_ONE));
    assign count_d = (start || last) ? branch_pkg::T_ZERO : count_q + branch_pkg::T_ONE;

    // counter state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= branch_pkg::T_ZERO;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

// File: bench/prog_mem.sv
/*
 * program memory on the far side of the branch block: combinational read.
 * assumes the bench loads bytes into mem before the block fetches them.
 */
`timescale 1ns/1ns
module prog_mem (
    input wire logic [15:0] addr, // read address
    input wire logic rd, // read strobe
    output logic [7:0] data // read data
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // a released bus shows the inverse of the last byte, so a late sample is caught
    assign data = rd ? mem[addr] : ~last_q;
    always @(data) begin
        if (rd) begin
            last_q = data;
        end
    end
endmodule

// File: bench/branch_props.sv
/*
 * checker for the branch block: instruction lengths, pulses and flag passing.
 * assumes it is bound to branch_jump_execution and sees only its ports.
 */
`timescale 1ns/1ns
module branch_props (
    input wire logic CLK, // core clock
    input wire logic RST_N, // async reset, active low
    input wire logic START, // instruction start
    input wire logic [7:0] FLAGS_IN, // flags from the core
    input wire logic [7:0] FLAGS_OUT, // flags passed back
    input wire logic [15:0] MEM_ADDR, // fetch address
    input wire logic MEM_RD, // read strobe
    input wire logic [15:0] PC_OUT, // program counter
    input wire logic [7:0] LOOP_COUNT_OUT, // decremented counter
    input wire logic LOOP_COUNT_WE, // counter write pulse
    input wire logic BRANCH_TAKEN, // taken pulse
    input wire logic UNKNOWN_OP, // foreign opcode pulse
    input wire logic BUSY, // instruction in progress
    input wire logic DONE // instruction finished
);
    logic [4:0] busy_cnt_q;
    logic [4:0] busy_cnt_d;
    // t-states spent busy; saturates so a hung design cannot wrap into a legal count
    assign busy_cnt_d = !BUSY ? 5'h00 : (busy_cnt_q == 5'h1F ? busy_cnt_q : busy_cnt_q + 5'h01);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_cnt_q <= 5'h00;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    default clocking dcb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // the write-back comes with the end of a loop that falls through, and five cycles before the end of a taken one
    sequence loop_fall_s; ##[0:1] (DONE && !BRANCH_TAKEN); endsequence
    sequence loop_jump_s; ##[4:5] (DONE && BRANCH_TAKEN); endsequence
    done_pulse_a: assert property (DONE |=> !DONE) else $error("done held too long");
    taken_marks_a: assert property ((BRANCH_TAKEN || UNKNOWN_OP) |-> DONE && !(BRANCH_TAKEN && UNKNOWN_OP))
        else $error("end pulse without done");
    busy_ends_a: assert property ($fell(BUSY) |-> DONE) else $error("busy fell without done");
    taken_length_a: assert property (DONE && BRANCH_TAKEN |-> busy_cnt_q inside {4, 8, 12, 13})
        else $error("taken branch has wrong length");
    fall_length_a: assert property (DONE && !BRANCH_TAKEN && !UNKNOWN_OP |-> busy_cnt_q inside {7, 8})
        else $error("untaken branch has wrong length");
    loop_zero_a: assert property (LOOP_COUNT_WE && LOOP_COUNT_OUT == 8'h00 |-> loop_fall_s)
        else $error("zero loop count still branched");
    loop_jump_a: assert property (LOOP_COUNT_WE && LOOP_COUNT_OUT != 8'h00 |-> loop_jump_s)
        else $error("nonzero loop count did not branch");
    flags_kept_a: assert property ($past(RST_N) |-> FLAGS_OUT == $past(FLAGS_IN))
        else $error("flags altered");
    fetch_at_pc_a: assert property (START && !BUSY |=> BUSY && MEM_RD && MEM_ADDR == $past(PC_OUT))
        else $error("fetch not at program counter");
endmodule
bind branch_jump_execution branch_props props_u (.CLK(CLK), .RST_N(RST_N), .START(START),
    .FLAGS_IN(FLAGS_IN), .FLAGS_OUT(FLAGS_OUT), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .PC_OUT(PC_OUT), .LOOP_COUNT_OUT(LOOP_COUNT_OUT), .LOOP_COUNT_WE(LOOP_COUNT_WE),
    .BRANCH_TAKEN(BRANCH_TAKEN), .UNKNOWN_OP(UNKNOWN_OP), .BUSY(BUSY), .DONE(DONE));

// File: bench/tb.sv
/*
 * self-checking bench for the branch block: corner opcodes, then random ones.
 * assumes prog_mem as program store and branch_props bound to the design.
 */
`timescale 1ns/1ns
module tb;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic START = 1'b0;
    logic [7:0] FLAGS_IN = 8'h00;
    logic [15:0] POINTER_PAIR = 16'h0000;
    logic [15:0] INDEX_REG_FIRST = 16'h0000;
    logic [15:0] INDEX_REG_SECOND = 16'h0000;
    logic [7:0] LOOP_COUNT_IN = 8'h00;
    logic [7:0] MEM_DATA, LOOP_COUNT_OUT, FLAGS_OUT;
    logic [15:0] MEM_ADDR, PC_OUT;
    logic MEM_RD, LOOP_COUNT_WE, BRANCH_TAKEN, UNKNOWN_OP, BUSY, DONE;
    int num_errors = 0;
    int checks = 0;
    logic [31:0] lfsr_q = 32'h0001785A;
    logic [15:0] pc_e = 16'h0000;
    logic [7:0] ops [9] = '{8'h38, 8'h30, 8'h28, 8'h20, 8'hE9, 8'hDD, 8'hFD, 8'h10, 8'h00};
    prog_mem pm (.addr(MEM_ADDR), .rd(MEM_RD), .data(MEM_DATA));
    branch_jump_execution uut (.CLK(CLK), .RST_N(RST_N), .START(START), .MEM_DATA(MEM_DATA),
        .FLAGS_IN(FLAGS_IN), .POINTER_PAIR(POINTER_PAIR), .INDEX_REG_FIRST(INDEX_REG_FIRST),
        .INDEX_REG_SECOND(INDEX_REG_SECOND), .LOOP_COUNT_IN(LOOP_COUNT_IN), .MEM_ADDR(MEM_ADDR),
        .MEM_RD(MEM_RD), .PC_OUT(PC_OUT), .LOOP_COUNT_OUT(LOOP_COUNT_OUT), .LOOP_COUNT_WE(LOOP_COUNT_WE),
        .FLAGS_OUT(FLAGS_OUT), .BRANCH_TAKEN(BRANCH_TAKEN), .UNKNOWN_OP(UNKNOWN_OP), .BUSY(BUSY), .DONE(DONE));
    initial begin
        forever #50 CLK = ~CLK;
    end
    // next value of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected outcome of one instruction, worked out from the opcode rules alone
    function automatic logic exp_taken(input logic [7:0] op, input logic [7:0] flg, input logic [7:0] cnt);
        return (op == 8'h38 && flg[0]) || (op == 8'h30 && !flg[0]) || (op == 8'h28 && flg[6]) ||
            (op == 8'h20 && !flg[6]) || (op == 8'h10 && cnt != 8'h00) || (op inside {8'hE9, 8'hDD, 8'hFD});
    endfunction
    function automatic logic [15:0] exp_len(input logic [7:0] op, input logic taken, input logic rel);
        if (op == 8'h10) return taken ? 16'h000D : 16'h0008;
        if (rel) return taken ? 16'h000C : 16'h0007;
        return (op == 8'hDD || op == 8'hFD) ? 16'h0008 : 16'h0004;
    endfunction
    function automatic logic [15:0] exp_pc(input logic [7:0] op, input logic taken, input logic rel,
        input logic [7:0] b2);
        if (!rel && taken) return op == 8'hE9 ? POINTER_PAIR : (op == 8'hDD ? INDEX_REG_FIRST : INDEX_REG_SECOND);
        if (taken) return pc_e + 16'h0002 + {{8{b2[7]}}, b2};
        return pc_e + (rel ? 16'h0002 : 16'h0001);
    endfunction
    task automatic compare(input logic [15:0] seen, input logic [15:0] want, input string what);
        checks++;
        if (seen !== want) begin
            num_errors++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one instruction at the expected pc; called just after a clock edge
    task automatic run(input logic [7:0] op, input logic [7:0] b2);
        logic [15:0] want, len;
        logic taken, rel, unk, we_seen;
        logic [7:0] cnt;
        int n;
        if (op == 8'hDD || op == 8'hFD) b2 = branch_pkg::OP_JUMP_POINTER;
        pm.mem[pc_e] = op;
        pm.mem[pc_e + 16'h0001] = b2;
        cnt = LOOP_COUNT_IN - 8'h01;
        rel = op inside {8'h38, 8'h30, 8'h28, 8'h20, 8'h10};
        unk = !rel && !(op inside {8'hE9, 8'hDD, 8'hFD});
        taken = exp_taken(op, FLAGS_IN, cnt);
        len = exp_len(op, taken, rel);
        want = exp_pc(op, taken, rel, b2);
        START = 1'b1;
        n = 0;
        we_seen = 1'b0;
        @(posedge CLK);
        #1 START = 1'b0;
        while (DONE !== 1'b1 && n < 40) begin
            @(posedge CLK);
            #1 n++;
            if (LOOP_COUNT_WE === 1'b1) begin
                we_seen = 1'b1;
                compare(16'(LOOP_COUNT_OUT), 16'(cnt), "loop count");
            end
        end
        compare(16'(n), len, "length");
        compare(PC_OUT, want, "pc");
        compare(16'(BRANCH_TAKEN), 16'(taken), "taken");
        compare(16'(UNKNOWN_OP), 16'(unk), "unknown");
        compare(16'(FLAGS_OUT), 16'(FLAGS_IN), "flags");
        compare(16'(we_seen), 16'(op == 8'h10), "loop write");
        pc_e = want;
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        #1 RST_N = 1'b1;
        @(posedge CLK);
        #1;
        // corners: both flag polarities, extreme displacements, count 1 and count wrap
        for (int i = 0; i < 18; i++) begin
            FLAGS_IN = i < 9 ? 8'h00 : 8'hFF;
            LOOP_COUNT_IN = i < 9 ? 8'h01 : 8'h00;
            POINTER_PAIR = 16'h4800 + 16'(i);
            INDEX_REG_FIRST = 16'hFFF0;
            INDEX_REG_SECOND = 16'h0100;
            run(ops[i % 9], i < 9 ? 8'h80 : 8'h7F);
        end
        $display("corner test finished");
        for (int i = 0; i < 200; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            FLAGS_IN = lfsr_q[7:0];
            LOOP_COUNT_IN = lfsr_q[15:8] & 8'h03;
            POINTER_PAIR = lfsr_q[31:16];
            lfsr_q = lfsr_next(lfsr_q);
            INDEX_REG_FIRST = lfsr_q[15:0];
            INDEX_REG_SECOND = lfsr_q[31:16];
            lfsr_q = lfsr_next(lfsr_q);
            run(ops[lfsr_q[7:0] % 9], lfsr_q[15:8]);
        end
        $display("random test finished");
        give_verdict;
    end
    // cuts a hang short well beyond the expected few hundred microseconds
    initial begin
        #3000000;
        num_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        give_verdict;
    end
endmodule
